// ### design/obr_consts.vh
// Constants shared by the overlap block buffer design files.
`ifndef OBR_CONSTS_VH
`define OBR_CONSTS_VH

// Fixed block and new-word sizes, in words.
`define OBR_WORDS_FULL    11'h400
`define OBR_WORDS_HALF    11'h200
`define OBR_WORDS_QUARTER 11'h100

// Smallest coded block or new-word count, and smallest coded warning point.
`define OBR_GROUP_MIN     11'h020
`define OBR_WARN_MIN      11'h010

// Mode select decodes shared by the new-word and warning-point selects.
`define OBR_SEL_FULL      2'h0
`define OBR_SEL_HALF      2'h1
`define OBR_SEL_QUARTER   2'h2
`define OBR_SEL_CODE      2'h3

// Configuration code fields on the output data pins during reset.
`define OBR_LEN_FIELD     4:0
`define OBR_NEW_FIELD     9:5
`define OBR_WARN_FIELD    15:10

// Mode input bit positions.
`define OBR_MODE_LEN      0
`define OBR_MODE_NEW      2:1
`define OBR_MODE_WARN     4:3
`define OBR_MODE_REAL     5

// Lane enables for the two 16-bit halves of a RAM word.
`define OBR_LANES_BOTH    2'h3
`define OBR_LANE_LOW      2'h1
`define OBR_LANE_HIGH     2'h2

`endif

// ### design/obr_ram.v
// Dual-lane 1K x 32 storage with per-half write enables and combinational read.
module obr_ram #(
  parameter LANE_W = 16,
  parameter ADDR_W = 10
) (
  // Clock.
  input  wire                  i_clk,
  // Write port.
  input  wire [1:0]            i_wr_lane,
  input  wire [ADDR_W-1:0]     i_wr_addr,
  input  wire [2*LANE_W-1:0]   i_wr_data,
  // Read port.
  input  wire [ADDR_W-1:0]     i_rd_addr,
  output wire [2*LANE_W-1:0]   o_rd_data
);

  genvar g;

  // Each half keeps its own array so the real-pair mode can fill one half at a time.
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_lane
      reg [LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

      // Lane write on the common clock.
      always @(posedge i_clk)
      begin
        if (i_wr_lane[g])
          mem[i_wr_addr] <= i_wr_data[g*LANE_W +: LANE_W];
      end

      assign o_rd_data[g*LANE_W +: LANE_W] = mem[i_rd_addr];
    end
  endgenerate

endmodule // obr_ram

// ### design/obr_buffer.v
// Overlap block buffer: synchronised writes, overlapped block reads and flags.
`include "obr_consts.vh"

module obr_buffer #(
  parameter DATA_W = 32,
  parameter ADDR_W = 10
) (
  // Read strobe, used as the block clock, and reset.
  input  wire              i_clk,
  input  wire              i_sys_rst,
  // Mode select inputs.
  input  wire              i_read_length_select,
  input  wire [1:0]        i_new_count_select,
  input  wire [1:0]        i_warn_point_select,
  input  wire              i_real_pair_mode,
  // Asynchronous write side.
  input  wire              i_write_strobe,
  input  wire              i_write_enable,
  input  wire [DATA_W-1:0] i_write_data,
  // Output data bus, three signals of a two-way pin group.
  input  wire [DATA_W-1:0] i_output_data_bus,
  output reg  [DATA_W-1:0] o_output_data_bus,
  output reg               o_output_data_bus_oe,
  // Flags.
  output reg               o_block_ready_flag,
  output reg               o_early_warning_flag
);

  localparam HALF_W = DATA_W / 2;
  localparam ST_IDLE = 2'b01;
  localparam ST_READ = 2'b10;

  // Synchroniser stages for all pins from outside the read strobe domain.
  reg              stb_s1;
  reg              stb_s2;
  reg              stb_s3;
  reg              wen_s1;
  reg              wen_s2;
  reg [DATA_W-1:0] wd_s1;
  reg [DATA_W-1:0] wd_s2;
  reg [DATA_W-1:0] pin_s1;
  reg [DATA_W-1:0] pin_s2;
  reg [5:0]        mode_s1;
  reg [5:0]        mode_s2;

  // Configuration caught during reset.
  reg [10:0]       blk_len;
  reg [10:0]       new_len;
  reg [10:0]       warn_len;
  reg              real_mode;

  // Write and read state.
  reg [ADDR_W-1:0] wr_addr;
  reg [10:0]       new_cnt;
  reg              fill_high;
  reg              pending;
  reg [ADDR_W-1:0] pend_start;
  reg [ADDR_W-1:0] rd_addr;
  reg [10:0]       rd_left;
  reg [1:0]        state;

  wire             wr_fire;
  wire [10:0]      next_cnt;
  wire             blk_done;
  wire             half_done;
  wire [1:0]       wr_lane;
  wire [DATA_W-1:0] wr_word;
  wire [DATA_W-1:0] rd_word;
  wire [ADDR_W-1:0] next_start;

  // Two flops per outside input, three on the strobe; the second stage feeds logic, and the strobe's third stage does too.
  always @(posedge i_clk)
  begin
    stb_s1  <= i_write_strobe;
    stb_s2  <= stb_s1;
    stb_s3  <= stb_s2;
    wen_s1  <= i_write_enable;
    wen_s2  <= wen_s1;
    wd_s1   <= i_write_data;
    wd_s2   <= wd_s1;
    pin_s1  <= i_output_data_bus;
    pin_s2  <= pin_s1;
    mode_s1 <= {i_real_pair_mode, i_warn_point_select, i_new_count_select, i_read_length_select};
    mode_s2 <= mode_s1;
  end

  // A write is a synchronised rising strobe edge with the enable high.
  assign wr_fire = stb_s2 & ~stb_s3 & wen_s2;

  // Real-pair mode puts the low input half into one RAM half per block.
  assign wr_word = real_mode ? {wd_s2[HALF_W-1:0], wd_s2[HALF_W-1:0]} : wd_s2;
  assign wr_lane = ~wr_fire ? 2'h0 :
                   ~real_mode ? `OBR_LANES_BOTH :
                   (fill_high ? `OBR_LANE_HIGH : `OBR_LANE_LOW);

  assign next_cnt   = new_cnt + 11'h001;
  assign half_done  = wr_fire && (next_cnt == new_len);
  // In real-pair mode a block is only complete once the second half is in.
  assign blk_done   = half_done && (!real_mode || fill_high);
  // Overlapped old data sits just behind the newest words, so start L words back.
  assign next_start = wr_addr + {{(ADDR_W-1){1'b0}}, 1'b1} - blk_len[ADDR_W-1:0];

  // Configuration is caught from the pins and mode inputs while reset is held.
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      real_mode <= mode_s2[`OBR_MODE_REAL];
      if (mode_s2[`OBR_MODE_REAL])
        blk_len <= `OBR_WORDS_FULL;
      else if (mode_s2[`OBR_MODE_LEN])
        blk_len <= {1'b0, pin_s2[`OBR_LEN_FIELD], 5'h00} + `OBR_GROUP_MIN;
      else
        blk_len <= `OBR_WORDS_FULL;
      if (mode_s2[`OBR_MODE_REAL])
        new_len <= `OBR_WORDS_FULL;
      else
        case (mode_s2[`OBR_MODE_NEW])
          `OBR_SEL_FULL:    new_len <= `OBR_WORDS_FULL;
          `OBR_SEL_HALF:    new_len <= `OBR_WORDS_HALF;
          `OBR_SEL_QUARTER: new_len <= `OBR_WORDS_QUARTER;
          default:          new_len <= {1'b0, pin_s2[`OBR_NEW_FIELD], 5'h00} + `OBR_GROUP_MIN;
        endcase
      case (mode_s2[`OBR_MODE_WARN])
        `OBR_SEL_FULL:    warn_len <= `OBR_WORDS_FULL;
        `OBR_SEL_HALF:    warn_len <= `OBR_WORDS_HALF;
        `OBR_SEL_QUARTER: warn_len <= `OBR_WORDS_QUARTER;
        default:          warn_len <= {1'b0, pin_s2[`OBR_WARN_FIELD], 4'h0} + `OBR_WARN_MIN;
      endcase
    end
  end

  // Write address, new-word count and completed-block bookkeeping.
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      wr_addr    <= {ADDR_W{1'b0}};
      new_cnt    <= 11'h000;
      fill_high  <= 1'b0;
      pending    <= 1'b0;
      pend_start <= {ADDR_W{1'b0}};
    end
    else
    begin
      if (wr_fire)
      begin
        // Real-pair mode refills the same 1024 addresses for each half.
        if (half_done && real_mode && !fill_high)
          wr_addr <= {ADDR_W{1'b0}};
        else
          wr_addr <= wr_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
        new_cnt <= half_done ? 11'h000 : next_cnt;
        if (half_done && real_mode)
          fill_high <= ~fill_high;
      end
      // A completed block waits here until the current read has finished.
      if (blk_done)
      begin
        pending    <= 1'b1;
        pend_start <= real_mode ? {ADDR_W{1'b0}} : next_start;
      end
      else if (state == ST_IDLE && pending && !wr_fire)
        pending <= 1'b0;
    end
  end

  // Read sequencer; a write cycle pauses it and drops the ready flag.
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state                <= ST_IDLE;
      rd_addr              <= {ADDR_W{1'b0}};
      rd_left              <= 11'h000;
      o_block_ready_flag   <= 1'b0;
      o_output_data_bus    <= {DATA_W{1'b0}};
      o_output_data_bus_oe <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          // Start is held off while a write takes this cycle.
          if (pending && !wr_fire)
          begin
            state                <= ST_READ;
            o_output_data_bus    <= rd_word;
            o_output_data_bus_oe <= 1'b1;
            o_block_ready_flag   <= 1'b1;
            rd_addr              <= pend_start + {{(ADDR_W-1){1'b0}}, 1'b1};
            rd_left              <= blk_len - 11'h001;
          end
        end
        ST_READ:
        begin
          if (rd_left == 11'h000 && o_block_ready_flag)
          begin
            // The last word was taken on this edge.
            state                <= ST_IDLE;
            o_block_ready_flag   <= 1'b0;
            o_output_data_bus_oe <= 1'b0;
          end
          else if (wr_fire)
            o_block_ready_flag <= 1'b0;
          else if (rd_left == 11'h000)
          begin
            // Last word was taken just before a stolen cycle.
            state                <= ST_IDLE;
            o_output_data_bus_oe <= 1'b0;
          end
          else
          begin
            o_output_data_bus  <= rd_word;
            o_block_ready_flag <= 1'b1;
            rd_addr            <= rd_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
            rd_left            <= rd_left - 11'h001;
          end
        end
        default:
        begin
          state                <= ST_IDLE;
          o_block_ready_flag   <= 1'b0;
          o_output_data_bus_oe <= 1'b0;
        end
      endcase
    end
  end

  // Early warning: raised at the programmed count, dropped at block end; a set wins.
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_early_warning_flag <= 1'b0;
    else if (wr_fire && next_cnt == warn_len && (!real_mode || fill_high))
      o_early_warning_flag <= 1'b1;
    else if (state == ST_READ && rd_left == 11'h000)
      o_early_warning_flag <= 1'b0;
  end

  // The read address comes from the idle start point or the running pointer.
  obr_ram #(
    .LANE_W (HALF_W),
    .ADDR_W (ADDR_W)
  ) obr_ram_inst (
    .i_clk     (i_clk),
    .i_wr_lane (wr_lane),
    .i_wr_addr (wr_addr),
    .i_wr_data (wr_word),
    .i_rd_addr ((state == ST_IDLE) ? pend_start : rd_addr),
    .o_rd_data (rd_word)
  );

endmodule // obr_buffer

// ### test/obr_buffer_monitor.sv
// Port checker for the overlap block buffer.
module obr_buffer_monitor (
  input wire        i_clk,
  input wire        i_sys_rst,
  input wire [31:0] o_output_data_bus,
  input wire        o_output_data_bus_oe,
  input wire        o_block_ready_flag,
  input wire        o_early_warning_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  // Short aliases keep the properties readable.
  wire        oe   = o_output_data_bus_oe;
  wire        rdy  = o_block_ready_flag;
  wire        warn = o_early_warning_flag;
  wire [31:0] dat  = o_output_data_bus;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_reset_float: assert property (disable iff (1'b0) i_sys_rst |=> !oe && !rdy && !warn)
    else $error("bus or flag active in reset");
  a_drive_with_ready: assert property ($rose(oe) |-> $rose(rdy))
    else $error("bus driven apart from ready");
  a_float_with_ready: assert property ($fell(oe) |-> $fell(rdy))
    else $error("bus floated apart from ready");
  a_ready_needs_bus: assert property (rdy |-> oe)
    else $error("ready with bus floating");
  a_gap_single: assert property (oe && !rdy |=> rdy)
    else $error("ready gap over one cycle");
  a_gap_data_held: assert property (oe && !rdy |-> $stable(dat))
    else $error("data moved in a gap");
  a_warn_end: assert property ($fell(oe) |-> !warn)
    else $error("warning outlived block");
  a_no_early_ready: assert property ($fell(i_sys_rst) |-> !rdy [*8])
    else $error("ready before any block");
  // Main scenarios: block start, write gap, warning.
  c_block: cover property ($rose(oe));
  c_gap: cover property (oe && !rdy);
  c_warn: cover property ($rose(warn));
endmodule // obr_buffer_monitor

bind obr_buffer obr_buffer_monitor obr_buffer_monitor_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .o_output_data_bus(o_output_data_bus), .o_output_data_bus_oe(o_output_data_bus_oe),
  .o_block_ready_flag(o_block_ready_flag), .o_early_warning_flag(o_early_warning_flag));

// ### test/obr_source_model.sv
// Slow sampling source that writes on its own 80 ns strobe.
module obr_source_model (
  input  wire logic        i_run,
  output logic             o_strobe,
  output logic             o_enable,
  output logic [31:0]      o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  integer seed = 32'h59061ee7;
  // Data changes at strobe fall, so it is stable for four clocks either side of the rise.
  initial
  begin
    o_strobe = 0;
    o_enable = 0;
    o_data = 0;
    #3;
    forever
    begin
      if (i_run)
      begin
        o_data = $random(seed);
        o_enable = ($random(seed) & 32'h7) != 0;
        #40 o_strobe = 1;
        #40 o_strobe = 0;
      end
      else
        #10;
    end
  end
endmodule // obr_source_model

// ### test/test_obr_buffer.sv
// Self-checking bench for the overlap block buffer.
module test_obr_buffer;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk = 0, i_sys_rst = 1, rls = 0, rp = 0, run = 0;
  logic [1:0]  ncs = 0, wps = 0;
  logic [31:0] code = 0, hist [0:2047];
  wire  [31:0] bus_pin, bus_out, wdat;
  wire         oe, rdy, warn, stb, wen;
  integer      seed = 32'h59061ee7, fails = 0, n_checks = 0, cyc = 0, wc = 0;
  integer      nb = 0, got = 0, ptr = 0, len = 0, nw = 1, wpt = 0, blk = 0, k;
  // Codes sit on the pins only during reset; otherwise the inverted code while the bus floats, or the driven bus.
  assign bus_pin = oe ? bus_out : (i_sys_rst ? code : ~code);
  obr_buffer obr_buffer_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_read_length_select(rls),
    .i_new_count_select(ncs), .i_warn_point_select(wps), .i_real_pair_mode(rp), .i_write_strobe(stb),
    .i_write_enable(wen), .i_write_data(wdat), .i_output_data_bus(bus_pin), .o_output_data_bus(bus_out),
    .o_output_data_bus_oe(oe), .o_block_ready_flag(rdy), .o_early_warning_flag(warn));
  obr_source_model obr_source_model_inst (.i_run(run), .o_strobe(stb), .o_enable(wen), .o_data(wdat));
  initial forever #5 i_clk = ~i_clk;
  task check(input logic [31:0] seen, exp, input string what);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Real-pair words put the second block on the high half.
  function logic [31:0] exp_word(input integer i);
    exp_word = rp ? {hist[i][15:0], hist[i - 1024][15:0]} : hist[i];
  endfunction
  // Mirror of every accepted write, in order.
  always @(posedge stb)
  begin
    if (wen === 1'b1)
    begin
      hist[wc] = wdat;
      wc = wc + 1;
    end
  end
  // Consumer takes a word on each edge where ready is high.
  always @(posedge i_clk)
  begin
    if (oe === 1'b1 && blk == 0)
    begin
      blk = 1;
      nb = nb + 1;
      ptr = nb * nw - len;
      got = 0;
      check(warn, wpt <= nw, "warning");
    end
    if (blk == 1 && rdy === 1'b1)
    begin
      if (ptr + got >= 0)
        check(bus_out, exp_word(ptr + got), "word");
      got = got + 1;
    end
    if (blk == 1 && oe !== 1'b1)
    begin
      blk = 0;
      check(got, len, "length");
    end
    cyc = cyc + 1;
    if (cyc == 90000)
    begin
      fails = fails + 1;
      conclude;
    end
  end
  // One configuration: reset with modes and codes, stream writes, drain blocks.
  task run_case(input logic l, input logic [1:0] n, w, input logic r, input logic [31:0] c,
                input integer writes, ln, nn, wp);
    @(posedge i_clk);
    #1;
    rls = l;
    ncs = n;
    wps = w;
    rp = r;
    code = c;
    len = ln;
    nw = nn;
    wpt = wp;
    i_sys_rst = 1;
    repeat (20) @(posedge i_clk);
    #1;
    i_sys_rst = 0;
    wc = 0;
    nb = 0;
    run = 1;
    wait (wc == writes);
    run = 0;
    for (k = 0; k < 3000 && !(nb == writes / nw && blk == 0); k = k + 1)
      @(posedge i_clk);
    check(nb, writes / nw, "blocks");
  endtask
  initial
  begin
    run_case(0, 0, 1, 0, $random(seed), 1024, 1024, 1024, 512);
    run_case(0, 1, 0, 0, $random(seed), 1536, 1024, 512, 1024);
    run_case(0, 2, 2, 0, $random(seed), 1280, 1024, 256, 256);
    run_case(1, 3, 3, 0, ($random(seed) & 32'hffff0000) | 32'h0823, 320, 128, 64, 48);
    run_case(0, 0, 1, 1, $random(seed), 2048, 1024, 2048, 512);
    conclude;
  end
endmodule // test_obr_buffer
